// File: serial_port_params.svh
// Constants for the serial port: reset values, frame sizes and clock divides.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

`define SP_FIFO_DEPTH 4
`define SP_FIFO_WIDTH 8
`define SP_DIV_SYS4 6'h03
`define SP_DIV_SYS12 6'h0B
`define SP_DIV12_SECOND 6'h17
`define SP_DIV12_THIRD 6'h23
`define SP_DIV_SYS48 6'h2F
`define SP_DIV_OSC8 3'h7
`define SP_TIMER_TOP 8'hFF
`define SP_BITS_8BIT 4'hA
`define SP_BITS_9BIT 4'hB
`define SP_DATA_BITS 3'h7
`define SP_FRAME_IDLE 11'h7FF
`define SP_RST_BYTE 8'h00
`define SP_RST_COUNT 8'h00

`endif

// File: serial_port_pkg.sv
// Types shared by the serial port design files.
package serial_port_pkg;

    typedef enum logic [2:0]
    {
        SRC_SYS,
        SRC_SYS_DIV4,
        SRC_SYS_DIV12,
        SRC_SYS_DIV48,
        SRC_OSC_DIV8,
        SRC_EXT_PIN
    } clk_src_t;

    typedef enum logic [0:0]
    {
        TX_IDLE,
        TX_BUSY
    } tx_state_t;

    typedef enum logic [2:0]
    {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_NINTH,
        RX_STOP
    } rx_state_t;

endpackage

// File: sync_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and registered flags.
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,              // System clock.
    input wire logic nrst_i,             // Asynchronous reset, active low.
    input wire logic in_valid_i,         // Writer offers a word.
    input wire logic [WIDTH-1:0] in_data_i, // Word offered.
    output logic in_ready_o,             // Room for a word, registered.
    output logic out_valid_o,            // Word available, registered.
    output logic [WIDTH-1:0] out_data_o, // Oldest word.
    input wire logic out_ready_i         // Reader takes the word.
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_ptr_q];

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
            count_d = count_q + CW'(1);
        else if (pop && !push)
            count_d = count_q - CW'(1);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            count_q <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            in_ready_o <= (count_d != CW'(DEPTH));
            out_valid_o <= (count_d != '0);
        end
    end

    // Pointers wrap by hand so a depth that is not a power of two still works.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
            if (pop)
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data_i;
    end
endmodule

// File: serial_port.sv
// Full-duplex asynchronous serial port with its timer-based bit clocks.
// Summary of operation
// - Asynchronous full duplex, 8-bit or 9-bit frames, both at variable bit rate.
// - Every data write the queue accepts goes to the transmit side, whatever the receiver does.
// - Data reads return the receive buffer; transmit data is never readable.
// - Receive is double buffered; a new byte may arrive before the old is read.
// - With interrupts enabled, a set done flag raises the interrupt.
// - Done flags stay set until software clears them.
// - Bit timing comes from an 8-bit auto-reload timer.
// - Transmit uses the timer low count; receive uses a hidden copy.
// - Each counter's overflows are halved to give its bit rate.
// - Receive counter runs with the timer and shares the reload value.
// - A start edge forces a reload of the receive counter.
// - Timer clock picks one of six sources.
// - Bit rate is timer clock over 256 minus reload, halved.
// - 8-bit frame: start, eight data bits LSB first, stop into ninth field.
// - 9-bit frame sends the written ninth bit; received ninth kept, stop ignored.
// - Transmit done sets at the start of the stop bit.
// - Received byte loads only if the flag is clear and filtering passes.
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_port (
    input wire logic clk_i,                    // System clock, 50 MHz.
    input wire logic nrst_i,                   // Asynchronous reset, active low.
    input wire logic data_wr_i,                // Write strobe for the data buffer.
    input wire logic [7:0] data_wr_byte_i,     // Byte written to the data buffer.
    output logic tx_ready_o,                   // Transmit queue can take a byte.
    output logic [7:0] data_rd_byte_o,         // Buffered receive byte.
    input wire logic frame_mode_select_i,      // 0: 8-bit frames, 1: 9-bit frames.
    input wire logic multiproc_filter_en_i,    // Load only when ninth or stop bit is 1.
    input wire logic rx_enable_bit_i,          // Receiver enable.
    input wire logic tx_ninth_bit_i,           // Ninth bit sent in 9-bit frames.
    output logic rx_ninth_bit_o,               // Received ninth bit or stop bit.
    output logic tx_done_flag_o,               // Transmit complete, sticky.
    output logic rx_done_flag_o,               // Receive complete, sticky.
    input wire logic tx_done_clr_i,            // Clears the transmit done flag.
    input wire logic rx_done_clr_i,            // Clears the receive done flag.
    input wire logic irq_en_i,                 // Interrupt enable.
    output logic irq_o,                        // Interrupt request, level.
    input wire logic timer_run_i,              // Baud timer enable.
    input wire serial_port_pkg::clk_src_t timer_clk_sel_i, // Timer clock source.
    input wire logic [7:0] baud_timer_reload_i, // Reload value of the timer.
    input wire logic timer_ext_input_i,        // External timer input pin.
    input wire logic ext_osc_i,                // External oscillator clock level.
    output logic serial_tx_pin_o,              // Serial transmit line.
    input wire logic serial_rx_pin_i           // Serial receive line.
);
    import serial_port_pkg::*;

    logic [5:0] pre_q;
    logic [2:0] osc_div_q;
    logic osc_prev_q;
    logic ext_prev_q;
    logic tick;
    logic [7:0] baud_timer_low_count_q;
    logic [7:0] rx_count_q;
    logic tx_ovf;
    logic rx_ovf;
    logic tx_half_q;
    logic rx_half_q;
    logic tx_baud;
    logic rx_sample;
    logic rx_prev_q;
    logic start_seen;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_pop;
    tx_state_t tx_state_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic tx_done_set;
    rx_state_t rx_state_q;
    logic [7:0] rx_sh_q;
    logic [2:0] rx_bit_q;
    logic rx_b9_q;
    logic rx_end;
    logic rx_load;
    logic rx_b9_final;

    // Prescaler edges are built from the one system clock, so the timer never
    // runs in a second domain; the external sources must be slower than clk_i/2.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pre_q <= '0;
            osc_div_q <= '0;
            osc_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            osc_prev_q <= ext_osc_i;
            ext_prev_q <= timer_ext_input_i;
            if (pre_q == `SP_DIV_SYS48)
                pre_q <= '0;
            else
                pre_q <= pre_q + 6'h01;
            if (ext_osc_i && !osc_prev_q)
                osc_div_q <= osc_div_q + 3'h1;
        end
    end

    always_comb
    begin
        tick = 1'b0;
        case (timer_clk_sel_i)
            SRC_SYS: tick = 1'b1;
            SRC_SYS_DIV4: tick = (pre_q[1:0] == 2'(`SP_DIV_SYS4));
            SRC_SYS_DIV12: tick = (pre_q == `SP_DIV_SYS12) || (pre_q == `SP_DIV12_SECOND)
                || (pre_q == `SP_DIV12_THIRD) || (pre_q == `SP_DIV_SYS48);
            SRC_SYS_DIV48: tick = (pre_q == `SP_DIV_SYS48);
            SRC_OSC_DIV8: tick = ext_osc_i && !osc_prev_q && (osc_div_q == `SP_DIV_OSC8);
            SRC_EXT_PIN: tick = timer_ext_input_i && !ext_prev_q;
            default: tick = 1'b0;
        endcase
        tick = tick && timer_run_i;
    end

    // Both counters wrap from the top to the shared reload value.
    assign tx_ovf = tick && (baud_timer_low_count_q == `SP_TIMER_TOP);
    assign rx_ovf = tick && (rx_count_q == `SP_TIMER_TOP) && !start_seen;
    assign tx_baud = tx_ovf && tx_half_q;
    assign rx_sample = rx_ovf && !rx_half_q;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            baud_timer_low_count_q <= `SP_RST_COUNT;
            tx_half_q <= 1'b0;
        end
        else if (tick)
        begin
            if (tx_ovf)
            begin
                baud_timer_low_count_q <= baud_timer_reload_i;
                tx_half_q <= !tx_half_q;
            end
            else
                baud_timer_low_count_q <= baud_timer_low_count_q + 8'h01;
        end
    end

    // The receive copy is realigned on the start edge, so its first overflow
    // lands half a bit later, in the middle of the start bit.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_count_q <= `SP_RST_COUNT;
            rx_half_q <= 1'b0;
        end
        else if (start_seen)
        begin
            rx_count_q <= baud_timer_reload_i;
            rx_half_q <= 1'b0;
        end
        else if (tick)
        begin
            if (rx_ovf)
            begin
                rx_count_q <= baud_timer_reload_i;
                rx_half_q <= !rx_half_q;
            end
            else
                rx_count_q <= rx_count_q + 8'h01;
        end
    end

    // A write while the queue is full is dropped; tx_ready_o tells the writer.
    sync_fifo #(
        .WIDTH(`SP_FIFO_WIDTH),
        .DEPTH(`SP_FIFO_DEPTH)
    ) tx_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(data_wr_i),
        .in_data_i(data_wr_byte_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(fifo_pop)
    );

    assign fifo_pop = (tx_state_q == TX_IDLE) && fifo_valid;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tx_state_q <= TX_IDLE;
            tx_sh_q <= `SP_FRAME_IDLE;
            tx_cnt_q <= '0;
            serial_tx_pin_o <= 1'b1;
        end
        else
        begin
            case (tx_state_q)
                TX_IDLE:
                begin
                    if (fifo_pop)
                    begin
                        // Stop (not shifted out in 8-bit frames), ninth (the stop in 8-bit frames), data LSB first, start.
                        tx_sh_q <= {1'b1, frame_mode_select_i ? tx_ninth_bit_i : 1'b1,
                            fifo_data, 1'b0};
                        tx_cnt_q <= frame_mode_select_i ? `SP_BITS_9BIT : `SP_BITS_8BIT;
                        tx_state_q <= TX_BUSY;
                    end
                end
                TX_BUSY:
                begin
                    if (tx_baud)
                    begin
                        if (tx_cnt_q == 4'h0)
                            tx_state_q <= TX_IDLE;
                        else
                        begin
                            serial_tx_pin_o <= tx_sh_q[0];
                            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                            tx_cnt_q <= tx_cnt_q - 4'h1;
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    assign tx_done_set = (tx_state_q == TX_BUSY) && tx_baud && (tx_cnt_q == 4'h1);

    // Set wins over a clear in the same cycle so no completion is lost.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            tx_done_flag_o <= 1'b0;
        else if (tx_done_set)
            tx_done_flag_o <= 1'b1;
        else if (tx_done_clr_i)
            tx_done_flag_o <= 1'b0;
    end

    assign start_seen = (rx_state_q == RX_IDLE) && rx_enable_bit_i
        && rx_prev_q && !serial_rx_pin_i;
    assign rx_end = (rx_state_q == RX_STOP) && rx_sample;
    assign rx_b9_final = frame_mode_select_i ? rx_b9_q : serial_rx_pin_i;
    assign rx_load = rx_end && !rx_done_flag_o
        && (!multiproc_filter_en_i || rx_b9_final);

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_state_q <= RX_IDLE;
            rx_prev_q <= 1'b1;
            rx_sh_q <= `SP_RST_BYTE;
            rx_bit_q <= '0;
            rx_b9_q <= 1'b0;
        end
        else
        begin
            rx_prev_q <= serial_rx_pin_i;
            case (rx_state_q)
                RX_IDLE:
                begin
                    if (start_seen)
                        rx_state_q <= RX_START;
                end
                RX_START:
                begin
                    // A line that is high again mid start bit was a glitch.
                    if (rx_sample)
                    begin
                        rx_state_q <= serial_rx_pin_i ? RX_IDLE : RX_DATA;
                        rx_bit_q <= '0;
                    end
                end
                RX_DATA:
                begin
                    if (rx_sample)
                    begin
                        rx_sh_q <= {serial_rx_pin_i, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == `SP_DATA_BITS)
                            rx_state_q <= frame_mode_select_i ? RX_NINTH : RX_STOP;
                    end
                end
                RX_NINTH:
                begin
                    if (rx_sample)
                    begin
                        rx_b9_q <= serial_rx_pin_i;
                        rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (rx_sample)
                        rx_state_q <= RX_IDLE;
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // The shift register keeps collecting while the holding register waits.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            data_rd_byte_o <= `SP_RST_BYTE;
            rx_ninth_bit_o <= 1'b0;
        end
        else if (rx_load)
        begin
            data_rd_byte_o <= rx_sh_q;
            rx_ninth_bit_o <= rx_b9_final;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rx_done_flag_o <= 1'b0;
        else if (rx_load)
            rx_done_flag_o <= 1'b1;
        else if (rx_done_clr_i)
            rx_done_flag_o <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_o <= 1'b0;
        else
            irq_o <= irq_en_i && (tx_done_flag_o || rx_done_flag_o);
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_irq_follows_flags: assert property ((irq_en_i && rx_done_flag_o) |=> irq_o)
        else $error("interrupt not raised for receive flag");
    a_irq_needs_enable: assert property (!$past(irq_en_i) |-> !irq_o)
        else $error("interrupt raised while disabled");
    a_tx_flag_sticky: assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o)
        else $error("transmit flag dropped without clear");
    a_rx_flag_sticky: assert property (rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o)
        else $error("receive flag dropped without clear");
    a_tx_done_at_stop: assert property ($rose(tx_done_flag_o) |-> serial_tx_pin_o
        && (tx_cnt_q == 4'h0))
        else $error("transmit flag not at stop bit");
    a_rx_hold_stable: assert property (rx_done_flag_o |=> $stable(data_rd_byte_o))
        else $error("receive buffer overwritten while full");
    a_rx_filter: assert property (rx_end && multiproc_filter_en_i && !rx_b9_final
        |=> !$rose(rx_done_flag_o))
        else $error("filtered frame was loaded");
    a_start_reload: assert property (start_seen |=>
        rx_count_q == $past(baud_timer_reload_i) && !rx_half_q)
        else $error("receive counter not reloaded at start");
    a_tx_reload: assert property (tx_ovf |=> baud_timer_low_count_q
        == $past(baud_timer_reload_i))
        else $error("transmit counter did not reload");
    a_tx_idle_high: assert property (tx_state_q == TX_IDLE |-> serial_tx_pin_o)
        else $error("transmit line low while idle");
    a_rx_no_run_off: assert property (!timer_run_i && !start_seen |=> $stable(rx_count_q))
        else $error("receive counter ran with timer stopped");
endmodule

// File: serial_partner.sv
// Remote serial transceiver model facing the port's pins.
`timescale 1ns/1ps
module serial_partner (
    input wire logic clk_i, // System clock.
    input wire logic line_i, // Port transmit line.
    output logic line_o, // Port receive line, idle high.
    input int bit_i // Bit time in clock cycles.
);
    logic [8:0] got_q[$];
    initial line_o = 1'b1;
    // Sampling starts a bit and a half after the start edge; bit 8 is the ninth or stop bit.
    initial
    begin
        logic [8:0] w;
        forever
        begin
            @(negedge line_i);
            repeat (bit_i / 2) @(negedge clk_i);
            for (int i = 0; i < 9; i++)
            begin
                repeat (bit_i) @(negedge clk_i);
                w[i] = line_i;
            end
            got_q.push_back(w);
        end
    end
    // Always sends eleven bit times; in 8-bit frames the last is extra idle.
    task automatic send(input logic [8:0] w, input logic nine);
        logic [10:0] f;
        f = nine ? {1'b1, w, 1'b0} : {2'h3, w[7:0], 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clk_i);
            line_o = f[i];
            repeat (bit_i - 1) @(negedge clk_i);
        end
    endtask
endmodule

// File: serial_port_tb.sv
// Self-checking bench for the serial port.
`timescale 1ns/1ps
module serial_port_tb;
    import serial_port_pkg::*;
    logic clk_i, nrst_i, data_wr_i, frame_mode_select_i, multiproc_filter_en_i;
    logic rx_enable_bit_i, tx_ninth_bit_i, tx_done_clr_i, rx_done_clr_i, irq_en_i;
    logic timer_run_i, rx_line, tx_ready_o, rx_ninth_bit_o, tx_done_flag_o;
    logic rx_done_flag_o, irq_o, serial_tx_pin_o, td_q;
    logic timer_ext_input_i = 1'b0;
    logic ext_osc_i = 1'b0;
    logic [1:0] ph = 2'h0;
    logic [7:0] data_wr_byte_i, baud_timer_reload_i, data_rd_byte_o;
    clk_src_t timer_clk_sel_i;
    int bit_cyc, err_total, compares;
    logic [31:0] seed = 32'h3C;
    logic [8:0] exp_q[$];

    serial_port serial_port_inst (.clk_i(clk_i), .nrst_i(nrst_i), .data_wr_i(data_wr_i),
        .data_wr_byte_i(data_wr_byte_i), .tx_ready_o(tx_ready_o),
        .data_rd_byte_o(data_rd_byte_o), .frame_mode_select_i(frame_mode_select_i),
        .multiproc_filter_en_i(multiproc_filter_en_i), .rx_enable_bit_i(rx_enable_bit_i),
        .tx_ninth_bit_i(tx_ninth_bit_i), .rx_ninth_bit_o(rx_ninth_bit_o),
        .tx_done_flag_o(tx_done_flag_o), .rx_done_flag_o(rx_done_flag_o),
        .tx_done_clr_i(tx_done_clr_i), .rx_done_clr_i(rx_done_clr_i), .irq_en_i(irq_en_i),
        .irq_o(irq_o), .timer_run_i(timer_run_i), .timer_clk_sel_i(timer_clk_sel_i),
        .baud_timer_reload_i(baud_timer_reload_i), .timer_ext_input_i(timer_ext_input_i),
        .ext_osc_i(ext_osc_i), .serial_tx_pin_o(serial_tx_pin_o),
        .serial_rx_pin_i(rx_line));
    serial_partner serial_partner_inst (.clk_i(clk_i), .line_i(serial_tx_pin_o),
        .line_o(rx_line), .bit_i(bit_cyc));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // External sources run at a quarter of the clock, well inside the edge detector's reach.
    always @(negedge clk_i)
    begin
        ph <= ph + 2'h1;
        ext_osc_i <= ph[1];
        timer_ext_input_i <= ph[1];
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic int bits_of(clk_src_t s, logic [7:0] r);
        int d;
        case (s)
            SRC_SYS: d = 1;
            SRC_SYS_DIV4: d = 4;
            SRC_SYS_DIV12: d = 12;
            SRC_SYS_DIV48: d = 48;
            SRC_OSC_DIV8: d = 32;
            default: d = 4;
        endcase
        return 2 * d * (256 - int'(r));
    endfunction

    task automatic check(string what, logic [9:0] exp, logic [9:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic put(logic [7:0] b);
        @(negedge clk_i);
        data_wr_byte_i = b;
        data_wr_i = 1'b1;
        @(negedge clk_i);
        data_wr_i = 1'b0;
    endtask
    task automatic pull(int n);
        for (int i = 0; i < 40000 && serial_partner_inst.got_q.size() < n; i++)
            @(negedge clk_i);
        if (serial_partner_inst.got_q.size() < n)
            check("tx frames", 10'(n), 10'(serial_partner_inst.got_q.size()));
        repeat (n) check("tx frame", exp_q.pop_front(), serial_partner_inst.got_q.pop_front());
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic send(logic [8:0] w);
        serial_partner_inst.send(w, frame_mode_select_i);
    endtask
    function automatic logic [9:0] rx_view();
        return {rx_done_flag_o, rx_ninth_bit_o, data_rd_byte_o};
    endfunction

    // The stop bit must already be on the pin when the done flag rises.
    always @(negedge clk_i)
    begin
        if (tx_done_flag_o === 1'b1 && td_q === 1'b0)
            check("tx pin at done", 10'h1, serial_tx_pin_o);
        td_q <= tx_done_flag_o;
    end
    initial
    begin
        repeat (90000) @(posedge clk_i);
        err_total++;
        summarize();
    end

    initial
    begin
        logic [7:0] b;
        logic [7:0] c;
        int n;
        {nrst_i, data_wr_i, tx_done_clr_i, rx_done_clr_i, irq_en_i} = 5'h00;
        {frame_mode_select_i, multiproc_filter_en_i, tx_ninth_bit_i} = 3'h0;
        {rx_enable_bit_i, timer_run_i} = 2'h3;
        data_wr_byte_i = 8'h00;
        timer_clk_sel_i = SRC_SYS;
        baud_timer_reload_i = 8'hF0;
        bit_cyc = bits_of(SRC_SYS, 8'hF0);
        repeat (12) @(negedge clk_i);
        check("reset outs", 10'h30, {tx_ready_o, serial_tx_pin_o, tx_done_flag_o,
            rx_done_flag_o, irq_o, rx_ninth_bit_o});
        check("reset data", 10'h0, data_rd_byte_o);
        nrst_i = 1'b1;
        $display("Test reset done");
        timer_run_i = 1'b0;
        b = rnd();
        put(b);
        repeat (600) @(negedge clk_i);
        check("frozen tx", 10'h0, 10'(serial_partner_inst.got_q.size()));
        timer_run_i = 1'b1;
        exp_q.push_back({1'b1, b});
        pull(1);
        $display("Test timer run done");
        // Back-to-back writes until the queue refuses; the refused byte must never appear.
        @(negedge clk_i);
        data_wr_i = 1'b1;
        n = 0;
        while (tx_ready_o === 1'b1 && n < 9)
        begin
            data_wr_byte_i = rnd();
            exp_q.push_back({1'b1, data_wr_byte_i});
            n++;
            @(negedge clk_i);
        end
        data_wr_byte_i = 8'h5A;
        @(negedge clk_i);
        data_wr_i = 1'b0;
        check("queue depth", 10'h1, 10'(n >= 4 && n < 9));
        pull(n);
        repeat (400) @(negedge clk_i);
        check("dropped write", 10'h0, 10'(serial_partner_inst.got_q.size()));
        check("irq masked", 10'h2, {tx_done_flag_o, irq_o});
        irq_en_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("irq tx", 10'h3, {tx_done_flag_o, irq_o});
        pulse(tx_done_clr_i);
        check("tx clear", 10'h0, {tx_done_flag_o, irq_o});
        frame_mode_select_i = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            tx_ninth_bit_i = k[0];
            b = rnd();
            exp_q.push_back({k[0], b});
            put(b);
            pull(1);
        end
        $display("Test transmit done");
        pulse(tx_done_clr_i);
        frame_mode_select_i = 1'b0;
        b = rnd();
        c = rnd();
        send({1'b1, b});
        check("rx byte", {2'h3, b}, rx_view());
        check("irq rx", 10'h1, irq_o);
        // The flag is cleared while the next frame is already on the line.
        fork
            send({1'b1, c});
            begin
                repeat (3 * bit_cyc) @(negedge clk_i);
                pulse(rx_done_clr_i);
            end
        join
        check("rx second", {2'h3, c}, rx_view());
        send({1'b1, b});
        check("rx overrun", {2'h3, c}, rx_view());
        pulse(rx_done_clr_i);
        rx_enable_bit_i = 1'b0;
        send({1'b1, b});
        check("rx disabled", {2'h1, c}, rx_view());
        rx_enable_bit_i = 1'b1;
        frame_mode_select_i = 1'b1;
        multiproc_filter_en_i = 1'b1;
        send({1'b0, b});
        check("filter refuse", {2'h1, c}, rx_view());
        send({1'b1, b});
        check("filter pass", {2'h3, b}, rx_view());
        pulse(rx_done_clr_i);
        multiproc_filter_en_i = 1'b0;
        send({1'b0, c});
        check("rx ninth", {2'h2, c}, rx_view());
        pulse(rx_done_clr_i);
        frame_mode_select_i = 1'b0;
        $display("Test receive done");
        // Each source carries a frame each way at once.
        for (int s = 0; s < 6; s++)
        begin
            timer_clk_sel_i = clk_src_t'(s);
            baud_timer_reload_i = (s == 0) ? 8'hF0 : (s == 1 || s == 5) ? 8'hFC : 8'hFF;
            bit_cyc = bits_of(timer_clk_sel_i, baud_timer_reload_i);
            b = rnd();
            c = rnd();
            exp_q.push_back({1'b1, b});
            fork
                put(b);
                send({1'b1, c});
            join
            pull(1);
            check("rx source", {2'h3, c}, rx_view());
            pulse(rx_done_clr_i);
        end
        $display("Test clock sources done");
        summarize();
    end
endmodule
